// File: rsx_pkg.sv
// Shared constants and types for the rotate/subtract/xor/sleep unit
package rsx_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int RSX_DATA_W = 8;
    localparam int RSX_FADDR_W = 7;
    localparam int RSX_FILE_DEPTH = 128;
    localparam int RSX_BUS_AW = 10;
    localparam int RSX_BUS_DW = 32;
    localparam int RSX_CMD_W = 24;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [RSX_BUS_AW-1:0] RSX_OFF_ACC = 10'h000;
    localparam logic [RSX_BUS_AW-1:0] RSX_OFF_STATUS = 10'h004;
    localparam logic [RSX_BUS_AW-1:0] RSX_OFF_CMD = 10'h008;
    // Data registers are write-only words from 0x200 upward
    localparam int RSX_FILE_SEL_BIT = 9;
    localparam int RSX_FILE_IDX_LSB = 2;
    localparam int RSX_ST_BUSY_BIT = 5;
    localparam int RSX_ST_SLEEP_BIT = 6;

    // ************************************************************
    // Operation codes and destination select
    // ************************************************************
    localparam logic [2:0] RSX_OP_SLEEP = 3'h0;
    localparam logic [2:0] RSX_OP_ROTR = 3'h1;
    localparam logic [2:0] RSX_OP_LITSUB = 3'h2;
    localparam logic [2:0] RSX_OP_FILESUB = 3'h3;
    localparam logic [2:0] RSX_OP_XORLIT = 3'h4;
    localparam logic RSX_DEST_ACC = 1'b0;
    localparam logic RSX_DEST_FILE = 1'b1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic expiry_status_bit;
        logic sleep_entered_bit;
        logic zero;
        logic nibble_borrow_flag;
        logic carry;
    } rsx_flags_t;

    typedef struct packed {
        logic [RSX_DATA_W-1:0] lit;
        logic [4:0] rsvd;
        logic [RSX_FADDR_W-1:0] faddr;
        logic dest;
        logic [2:0] op;
    } rsx_cmd_t;

    typedef struct packed {
        logic [RSX_DATA_W-1:0] res;
        logic carry;
        logic nibble;
    } rsx_sub_t;

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SLEEP} rsx_state_t;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [RSX_DATA_W-1:0] RSX_ACC_RST = 8'h00;
    localparam logic [RSX_DATA_W-1:0] RSX_ZERO_BYTE = 8'h00;
    localparam rsx_flags_t RSX_FLAGS_RST = 5'h18;
    localparam rsx_cmd_t RSX_CMD_RST = 24'h000000;

endpackage : rsx_pkg

// File: rsx_file_mem.sv
// Data register file with registered read port
`timescale 1ns/1ps
`default_nettype none
module rsx_file_mem #(
    parameter int DEPTH = 128,
    parameter int DW = 8,
    parameter int AW = 7
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem_r [DEPTH];

    // Array has no reset so it can map onto RAM
    always_ff @(posedge mclk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem_r[raddr];
        end
    end
endmodule : rsx_file_mem
`default_nettype wire

// File: rsx_exec.sv
// Execution unit for sleep, rotate-right, two subtracts and xor-literal
// Function
// - Sleep clears the watchdog counter to 00h and its prescaler.
// - Sleep sets the expiry status bit and clears the sleep entered bit.
// - On the same clock edge as its status updates, sleep halts the main oscillator.
// - Rotate right moves a data register right through the carry.
// - Rotate right writes to the accumulator for dest 0, else the file.
// - Literal minus acc goes to acc, updating carry, nibble and zero.
// - There carry is set when acc <= literal, nibble borrow on bits 3:0.
// - File minus acc computes register minus acc with those three flags.
// - There carry is set when acc <= register, nibble borrow on 3:0.
// - File minus acc stores to acc for dest 0, else to the register.
// - Acc xor literal writes acc and updates only the zero flag.
`timescale 1ns/1ps
`default_nettype none
module rsx_exec
    import rsx_pkg::*;
#(
    parameter int FILE_DEPTH = RSX_FILE_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [RSX_BUS_AW-1:0] bus_addr,
    input wire logic [RSX_BUS_DW-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [RSX_BUS_DW-1:0] bus_rdata,
    output logic [RSX_DATA_W-1:0] acc_out,
    output rsx_flags_t flags_out,
    output logic sleeping,
    output logic osc_run,
    output logic wdog_count_clr,
    output logic wdog_prescale_clr
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic op_known(input logic [2:0] op);
        return (op == RSX_OP_SLEEP) || (op == RSX_OP_ROTR) ||
               (op == RSX_OP_LITSUB) || (op == RSX_OP_FILESUB) ||
               (op == RSX_OP_XORLIT);
    endfunction : op_known

    function automatic logic is_file_op(input logic [2:0] op);
        return (op == RSX_OP_ROTR) || (op == RSX_OP_FILESUB);
    endfunction : is_file_op

    // Minuend minus acc; carry means no borrow, i.e. acc <= minuend
    function automatic rsx_sub_t sub_calc(
        input logic [RSX_DATA_W-1:0] m,
        input logic [RSX_DATA_W-1:0] w
    );
        rsx_sub_t s;
        s.res = 8'(m - w);
        s.carry = (w <= m);
        s.nibble = (w[3:0] <= m[3:0]);
        return s;
    endfunction : sub_calc

    // ************************************************************
    // State
    // ************************************************************
    rsx_state_t state_r, state_nxt;
    rsx_cmd_t cmd_r, cmd_in;
    rsx_flags_t flags_r;
    logic [RSX_DATA_W-1:0] acc_r, mem_rdata, operand, res, mem_wdata;
    logic idle, sel_file, cmd_take, sleep_take, new_c, new_dc, upd_z;
    logic acc_wr, status_wr, file_bus_wr, exec_go, dest_file, mem_we;
    logic [2:0] exec_op;
    rsx_sub_t sub;
    logic [RSX_FADDR_W-1:0] mem_waddr;

    assign cmd_in = rsx_cmd_t'(bus_wdata[RSX_CMD_W-1:0]);
    assign idle = (state_r == ST_IDLE);
    assign sel_file = bus_addr[RSX_FILE_SEL_BIT];
    // Writes while busy or asleep are dropped: the slave never stalls
    assign cmd_take = bus_wr && idle && (bus_addr == RSX_OFF_CMD)
                      && op_known(cmd_in.op);
    assign sleep_take = cmd_take && (cmd_in.op == RSX_OP_SLEEP);
    assign acc_wr = bus_wr && idle && (bus_addr == RSX_OFF_ACC);
    assign status_wr = bus_wr && idle && (bus_addr == RSX_OFF_STATUS);
    assign file_bus_wr = bus_wr && idle && sel_file;

    // ************************************************************
    // Datapath
    // ************************************************************
    always_comb begin
        if (state_r == ST_FETCH) begin
            exec_op = cmd_r.op;
            operand = mem_rdata;
        end else begin
            exec_op = cmd_in.op;
            operand = cmd_in.lit;
        end
        exec_go = (state_r == ST_FETCH) ||
                  (cmd_take && !is_file_op(cmd_in.op) && !sleep_take);
        dest_file = (state_r == ST_FETCH) && (cmd_r.dest == RSX_DEST_FILE);
        sub = sub_calc(operand, acc_r);
        res = acc_r;
        new_c = flags_r.carry;
        new_dc = flags_r.nibble_borrow_flag;
        upd_z = 1'b0;
        case (exec_op)
            RSX_OP_ROTR: begin
                res = {flags_r.carry, operand[RSX_DATA_W-1:1]};
                new_c = operand[0];
            end
            RSX_OP_LITSUB, RSX_OP_FILESUB: begin
                res = sub.res;
                new_c = sub.carry;
                new_dc = sub.nibble;
                upd_z = 1'b1;
            end
            RSX_OP_XORLIT: begin
                res = acc_r ^ operand;
                upd_z = 1'b1;
            end
            default: begin
                res = acc_r;
            end
        endcase
    end

    // Writeback to the file has priority only in FETCH, where bus writes
    // to the file are refused, so the two never collide
    always_comb begin
        if (exec_go && dest_file) begin
            mem_we = 1'b1;
            mem_waddr = cmd_r.faddr;
            mem_wdata = res;
        end else begin
            mem_we = file_bus_wr;
            mem_waddr = bus_addr[RSX_FILE_IDX_LSB +: RSX_FADDR_W];
            mem_wdata = bus_wdata[RSX_DATA_W-1:0];
        end
    end

    rsx_file_mem #(
        .DEPTH(FILE_DEPTH),
        .DW(RSX_DATA_W),
        .AW(RSX_FADDR_W)
    ) u_mem (
        .mclk(mclk),
        .rst(rst),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .re(cmd_take && is_file_op(cmd_in.op)),
        .raddr(cmd_in.faddr),
        .rdata(mem_rdata)
    );

    // ************************************************************
    // Sequencing
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (sleep_take) begin
                    state_nxt = ST_SLEEP;
                end else if (cmd_take && is_file_op(cmd_in.op)) begin
                    state_nxt = ST_FETCH;
                end
            end
            ST_FETCH: begin
                state_nxt = ST_IDLE;
            end
            ST_SLEEP: begin
                state_nxt = ST_SLEEP;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmd_r <= RSX_CMD_RST;
        end else if (cmd_take) begin
            cmd_r <= cmd_in;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc_r <= RSX_ACC_RST;
        end else if (acc_wr) begin
            acc_r <= bus_wdata[RSX_DATA_W-1:0];
        end else if (exec_go && !dest_file) begin
            acc_r <= res;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags_r <= RSX_FLAGS_RST;
        end else if (status_wr) begin
            flags_r <= rsx_flags_t'(bus_wdata[$bits(rsx_flags_t)-1:0]);
        end else if (sleep_take) begin
            flags_r.expiry_status_bit <= 1'b1;
            flags_r.sleep_entered_bit <= 1'b0;
        end else if (exec_go) begin
            flags_r.carry <= new_c;
            flags_r.nibble_borrow_flag <= new_dc;
            if (upd_z) begin
                flags_r.zero <= (res == RSX_ZERO_BYTE);
            end
        end
    end

    // Clearing the watchdog is a one-cycle strobe to the watchdog itself
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wdog_count_clr <= 1'b0;
            wdog_prescale_clr <= 1'b0;
        end else begin
            wdog_count_clr <= sleep_take;
            wdog_prescale_clr <= sleep_take;
        end
    end

    // Only reset leaves sleep: wake-up sits outside this unit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            osc_run <= 1'b1;
            sleeping <= 1'b0;
        end else if (sleep_take) begin
            osc_run <= 1'b0;
            sleeping <= 1'b1;
        end
    end

    assign acc_out = acc_r;
    assign flags_out = flags_r;

    // ************************************************************
    // Register read port
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_rdata <= '0;
        end else begin
            bus_rdata <= '0;
            if (bus_rd && !sel_file) begin
                if (bus_addr == RSX_OFF_ACC) begin
                    bus_rdata[RSX_DATA_W-1:0] <= acc_r;
                end else if (bus_addr == RSX_OFF_STATUS) begin
                    bus_rdata[$bits(rsx_flags_t)-1:0] <= flags_r;
                    bus_rdata[RSX_ST_BUSY_BIT] <= (state_r == ST_FETCH);
                    bus_rdata[RSX_ST_SLEEP_BIT] <= (state_r == ST_SLEEP);
                end else if (bus_addr == RSX_OFF_CMD) begin
                    bus_rdata[RSX_CMD_W-1:0] <= cmd_r;
                end
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence seq_fsub_acc;
        cmd_take && cmd_in.op == RSX_OP_FILESUB && cmd_in.dest == RSX_DEST_ACC
        ##1 state_r == ST_FETCH;
    endsequence

    sequence seq_rotr_fetch;
        state_r == ST_FETCH && cmd_r.op == RSX_OP_ROTR;
    endsequence

    chk_sleep_wdog_clear: assert property (@(posedge mclk) disable iff (rst)
        sleep_take |=> wdog_count_clr && wdog_prescale_clr ##1 !wdog_count_clr)
        else $error("sleep did not pulse watchdog clear");

    chk_sleep_status_bits: assert property (@(posedge mclk) disable iff (rst)
        sleep_take |=> flags_r.expiry_status_bit && !flags_r.sleep_entered_bit
            && flags_r.carry == $past(flags_r.carry) && $stable(acc_r))
        else $error("sleep status update wrong");

    chk_sleep_osc_halt: assert property (@(posedge mclk) disable iff (rst)
        sleep_take |=> !osc_run [*3])
        else $error("oscillator still running in sleep");

    chk_rotr_carry_acc: assert property (@(posedge mclk) disable iff (rst)
        seq_rotr_fetch and cmd_r.dest == RSX_DEST_ACC |=>
            flags_r.carry == $past(mem_rdata[0]) &&
            acc_r == {$past(flags_r.carry), $past(mem_rdata[7:1])})
        else $error("rotate right result wrong");

    chk_rotr_dest_file: assert property (@(posedge mclk) disable iff (rst)
        seq_rotr_fetch and cmd_r.dest == RSX_DEST_FILE |=> $stable(acc_r))
        else $error("rotate to file disturbed accumulator");

    chk_litsub_value: assert property (@(posedge mclk) disable iff (rst)
        cmd_take && cmd_in.op == RSX_OP_LITSUB |=>
            acc_r == 8'($past(cmd_in.lit) - $past(acc_r)))
        else $error("literal minus acc wrong");

    chk_litsub_borrow: assert property (@(posedge mclk) disable iff (rst)
        cmd_take && cmd_in.op == RSX_OP_LITSUB |=>
            flags_r.carry == ($past(acc_r) <= $past(cmd_in.lit)) &&
            flags_r.nibble_borrow_flag ==
                ($past(acc_r[3:0]) <= $past(cmd_in.lit[3:0])))
        else $error("literal subtract flags wrong");

    chk_filesub_value: assert property (@(posedge mclk) disable iff (rst)
        seq_fsub_acc |=> acc_r == 8'($past(mem_rdata) - $past(acc_r)))
        else $error("file minus acc wrong");

    chk_filesub_borrow: assert property (@(posedge mclk) disable iff (rst)
        state_r == ST_FETCH && cmd_r.op == RSX_OP_FILESUB |=>
            flags_r.carry == ($past(acc_r) <= $past(mem_rdata)) &&
            flags_r.nibble_borrow_flag ==
                ($past(acc_r[3:0]) <= $past(mem_rdata[3:0])))
        else $error("file subtract flags wrong");

    chk_xor_only_zero: assert property (@(posedge mclk) disable iff (rst)
        cmd_take && cmd_in.op == RSX_OP_XORLIT |=>
            acc_r == ($past(acc_r) ^ $past(cmd_in.lit)) &&
            $stable(flags_r.carry) && $stable(flags_r.nibble_borrow_flag))
        else $error("xor literal wrong");

    chk_zero_flag: assert property (@(posedge mclk) disable iff (rst)
        cmd_take && (cmd_in.op == RSX_OP_XORLIT || cmd_in.op == RSX_OP_LITSUB)
            |=> flags_r.zero == (acc_r == RSX_ZERO_BYTE))
        else $error("zero flag wrong");

endmodule : rsx_exec
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the rotate/subtract/xor/sleep unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rsx_pkg::*;

    typedef struct {
        logic [2:0] op;
        logic [7:0] a;
        logic [7:0] v;
        logic [4:0] st;
        logic [7:0] res;
        logic [4:0] fl;
    } rsx_row_t;

    logic mclk;
    logic rst;
    logic [RSX_BUS_AW-1:0] bus_addr;
    logic [RSX_BUS_DW-1:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [RSX_BUS_DW-1:0] bus_rdata;
    logic [RSX_DATA_W-1:0] acc_out;
    rsx_flags_t flags_out;
    logic sleeping;
    logic osc_run;
    logic wdog_count_clr;
    logic wdog_prescale_clr;
    int n_mismatch = 0;
    int n_checks = 0;

    // ************************************************************
    // Ordinary cases: operands, flags loaded, expected result
    // ************************************************************
    rsx_row_t rows [15] = '{
        '{RSX_OP_LITSUB, 8'h05, 8'h05, 5'h18, 8'h00, 5'h1F},
        '{RSX_OP_LITSUB, 8'h06, 8'h05, 5'h1B, 8'hFF, 5'h18},
        '{RSX_OP_LITSUB, 8'h0F, 8'h10, 5'h18, 8'h01, 5'h19},
        '{RSX_OP_LITSUB, 8'h00, 8'hFF, 5'h1C, 8'hFF, 5'h1B},
        '{RSX_OP_LITSUB, 8'hFF, 8'h00, 5'h1F, 8'h01, 5'h18},
        '{RSX_OP_XORLIT, 8'hA5, 8'hA5, 5'h03, 8'h00, 5'h07},
        '{RSX_OP_XORLIT, 8'h3C, 8'hFF, 5'h04, 8'hC3, 5'h00},
        '{RSX_OP_XORLIT, 8'h00, 8'h00, 5'h18, 8'h00, 5'h1C},
        '{RSX_OP_ROTR, 8'h55, 8'h01, 5'h18, 8'h00, 5'h19},
        '{RSX_OP_ROTR, 8'h55, 8'h80, 5'h1D, 8'hC0, 5'h1C},
        '{RSX_OP_ROTR, 8'h55, 8'hFE, 5'h18, 8'h7F, 5'h18},
        '{RSX_OP_FILESUB, 8'h30, 8'h30, 5'h18, 8'h00, 5'h1F},
        '{RSX_OP_FILESUB, 8'h01, 8'h10, 5'h1E, 8'h0F, 5'h19},
        '{RSX_OP_FILESUB, 8'h81, 8'h7F, 5'h19, 8'hFE, 5'h1A},
        '{RSX_OP_FILESUB, 8'h00, 8'h00, 5'h00, 8'h00, 5'h07}
    };

    rsx_exec dut (
        .mclk(mclk),
        .rst(rst),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_rdata(bus_rdata),
        .acc_out(acc_out),
        .flags_out(flags_out),
        .sleeping(sleeping),
        .osc_run(osc_run),
        .wdog_count_clr(wdog_count_clr),
        .wdog_prescale_clr(wdog_prescale_clr)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] cmd_word(input logic [2:0] op,
        input logic d, input logic [6:0] idx, input logic [7:0] lit);
        return {8'h00, lit, 5'h00, idx, d, op};
    endfunction : cmd_word

    function automatic logic [9:0] file_addr(input logic [6:0] idx);
        return {1'b1, idx, 2'b00};
    endfunction : file_addr

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_data

    task automatic chk_bit(input logic got, input logic exp,
        input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit

    // Gap cycle after each write keeps the strobe to one driver per step
    task automatic bus_write(input logic [9:0] a, input logic [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
        @(posedge mclk);
    endtask : bus_write

    task automatic bus_read(input logic [9:0] a, input logic [31:0] exp);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1;
        chk_data(bus_rdata, exp, "read data");
        @(posedge mclk);
    endtask : bus_read

    task automatic chk_acc_flags(input logic [7:0] a, input logic [4:0] f);
        chk_data({24'h0, acc_out}, {24'h0, a}, "acc");
        chk_data({27'h0, flags_out}, {27'h0, f}, "flags");
    endtask : chk_acc_flags

    task automatic chk_reset_state();
        chk_acc_flags(RSX_ACC_RST, RSX_FLAGS_RST);
        chk_bit(sleeping, 1'b0, "sleeping");
        chk_bit(osc_run, 1'b1, "osc_run");
        chk_bit(wdog_count_clr | wdog_prescale_clr, 1'b0, "clear pulses");
        chk_data(bus_rdata, 32'h0, "rdata");
    endtask : chk_reset_state

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        $display("MISMATCH t=%0t run did not finish", $time);
        report_and_stop();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst = 1'b1;
        bus_addr = '0;
        bus_wdata = '0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (16) @(posedge mclk);
        #1;
        chk_reset_state();
        @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 15; i++) begin
            bus_write(RSX_OFF_ACC, {24'h0, rows[i].a});
            bus_write(RSX_OFF_STATUS, {27'h0, rows[i].st});
            if (rows[i].op == RSX_OP_ROTR || rows[i].op == RSX_OP_FILESUB) begin
                bus_write(file_addr(7'(i * 9)), {24'h0, rows[i].v});
            end
            bus_write(RSX_OFF_CMD,
                cmd_word(rows[i].op, RSX_DEST_ACC, 7'(i * 9), rows[i].v));
            #1;
            chk_acc_flags(rows[i].res, rows[i].fl);
            bus_read(RSX_OFF_STATUS, {27'h0, rows[i].fl});
        end
        // Write-back to the top register index, read back via f - 0
        bus_write(file_addr(7'h7F), 32'h03);
        bus_write(RSX_OFF_ACC, 32'h44);
        bus_write(RSX_OFF_STATUS, 32'h18);
        bus_addr <= RSX_OFF_CMD;
        bus_wdata <= cmd_word(RSX_OP_ROTR, RSX_DEST_FILE, 7'h7F, 8'h00);
        bus_wr <= 1'b1;
        @(posedge mclk);
        // Status read in the busy cycle still shows the old flags
        bus_wr <= 1'b0;
        bus_addr <= RSX_OFF_STATUS;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1;
        chk_data(bus_rdata, 32'h38, "busy status");
        chk_acc_flags(8'h44, 5'h19);
        @(posedge mclk);
        bus_write(RSX_OFF_CMD,
            cmd_word(RSX_OP_FILESUB, RSX_DEST_FILE, 7'h7F, 8'h00));
        #1;
        chk_acc_flags(8'h44, 5'h18);
        bus_write(RSX_OFF_ACC, 32'h00);
        bus_write(RSX_OFF_CMD,
            cmd_word(RSX_OP_FILESUB, RSX_DEST_ACC, 7'h7F, 8'h00));
        #1;
        chk_acc_flags(8'hBD, 5'h1B);
        // Write in the busy cycle must be dropped
        bus_write(file_addr(7'h05), 32'h20);
        bus_write(RSX_OFF_ACC, 32'h10);
        bus_write(RSX_OFF_STATUS, 32'h18);
        bus_addr <= RSX_OFF_CMD;
        bus_wdata <= cmd_word(RSX_OP_FILESUB, RSX_DEST_ACC, 7'h05, 0);
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_addr <= RSX_OFF_ACC;
        bus_wdata <= 32'hEE;
        @(posedge mclk);
        bus_wr <= 1'b0;
        @(posedge mclk);
        #1;
        chk_acc_flags(8'h10, 5'h1B);
        // Unknown op codes leave everything alone
        for (int k = 5; k < 8; k++) begin
            bus_write(RSX_OFF_CMD, cmd_word(3'(k), RSX_DEST_ACC, 7'h05, 8'hFF));
            chk_acc_flags(8'h10, 5'h1B);
        end
        bus_read(RSX_OFF_CMD, cmd_word(RSX_OP_FILESUB, RSX_DEST_ACC, 7'h05, 0));
        bus_read(RSX_OFF_ACC, 32'h10);
        bus_read(10'h00C, 32'h0);
        bus_read(file_addr(7'h05), 32'h0);
        #1;
        chk_data(bus_rdata, 32'h0, "rdata after one cycle");
        // Sleep: pulses for one cycle, status bits, oscillator stops
        bus_write(RSX_OFF_STATUS, 32'h0B);
        bus_addr <= RSX_OFF_CMD;
        bus_wdata <= cmd_word(RSX_OP_SLEEP, RSX_DEST_ACC, 0, 0);
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
        #1;
        chk_bit(wdog_count_clr, 1'b1, "count clear");
        chk_bit(wdog_prescale_clr, 1'b1, "prescale clear");
        chk_acc_flags(8'h10, 5'h13);
        chk_bit(osc_run, 1'b0, "osc_run");
        chk_bit(sleeping, 1'b1, "sleeping");
        @(posedge mclk);
        #1;
        chk_bit(wdog_count_clr | wdog_prescale_clr, 1'b0, "pulse end");
        bus_write(RSX_OFF_ACC, 32'h77);
        chk_acc_flags(8'h10, 5'h13);
        bus_read(RSX_OFF_STATUS, 32'h53);
        // Second reset in mid-run
        rst <= 1'b1;
        @(posedge mclk);
        #1;
        chk_reset_state();
        @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk_reset_state();
        @(posedge mclk);
        bus_write(RSX_OFF_CMD, cmd_word(RSX_OP_XORLIT, RSX_DEST_ACC, 0, 8'h5A));
        chk_acc_flags(8'h5A, 5'h18);
        report_and_stop();
    end

endmodule : tb_top
`default_nettype wire
